/* File: ssr_fifo.sv */
// small result buffer with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  ssr_fifo_if.dst wr,
  ssr_fifo_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  // honest flags: full stalls the writer, empty stalls the reader
  assign wr.ready = (cnt_ff != FULL);
  assign rd.valid = (cnt_ff != '0);
  assign rd.data = mem_ff[rp_ff];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // pointer and storage update
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = wr.data;
      nxt_wp = wp_ff + 1'b1;
    end
    if (pop) begin
      nxt_rp = rp_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!nrst)
    (cnt_ff == FULL && !pop) |=> (cnt_ff == FULL) && !wr.ready;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count left full");
endmodule

/* File: ssr_fifo_if.sv */
// valid/ready word channel between the readout logic and its result buffer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface ssr_fifo_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

/* File: ssr_host_model.sv */
// host serial port model: makes the external serial clock in short bursts
// assumes the testbench reads the capture arrays after each burst returns
`timescale 1ns/1ps
module ssr_host_model (
  output logic sclk,
  input wire logic data_in,
  input wire logic sync_in
);
  logic cap_d [0:31];
  logic cap_s [0:31];

  ////////////////////////////////////////////////////////////////////////
  // clock stands still low between bursts, as a discontinuous host would
  initial sclk = 1'b0;

  // n pulses; sample on the fall since the device moves data on the rise
  // 40 ns period, 20 ns phases
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      #20 sclk = 1'b1;
      #20 sclk = 1'b0;
      cap_d[i] = data_in;
      cap_s[i] = sync_in;
    end
  endtask
endmodule

/* File: ssr_pkg.sv */
// constants, state codes and pin positions of the converter readout logic
// assumes a 20 MHz system clock and a host-made or internally made serial clock
// Contract
// [RL1] Format select high gives straight binary, low gives two's complement.
// [RL2] External mode: sync pulse only after an idle-time serial clock edge.
// [RL3] External mode: chain input reaches serial data, delayed by read mode.
// [RL4] Busy stays low no longer than 2.2 us per conversion.
// [RL5] Internal mode: serial clock starts about 270 ns after strobe falls; the code starts it 300 ns after conversion start, 10 to 11 cycles after strobe.
// [RL6] Internal serial clock period is typically 110 ns; the code makes it 100 ns, two system cycles.
// [RL7] Host external serial clock: period >= 35 ns, phases >= 15 ns.
// [RL8] Host keeps final clock edge within 1 us of busy falling.
// [RL9] Host waits 2 us after both selects low for previous result.
// [RL10] Chip select and strobe are ORed; control acts only with both low.
// [RL11] Busy falls at conversion start, rises once the result is stored.
// [RL12] Internal mode: exactly 16 clock pulses per conversion, then held low.
// [RL13] External mode: after 16 bits output chain level while reading.
// [RL14] Host allows 1.8 us acquisition after busy rises.
// [RL15] Host holds the strobe low at least 40 ns.
package ssr_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_MAX_NS = 2200;
  // longest time, rounded down
  localparam int CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int SCLK_DELAY_NS = 270;
  localparam int SCLK_DELAY_CYC = SCLK_DELAY_NS / CLK_PERIOD_NS;
  localparam int SCLK_PERIOD_NS = 110;
  localparam int SCLK_HALF_RAW = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SCLK_HALF_CYC = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;
  localparam int WORD_W = 16;
  localparam int WORD_MSB = 15;
  localparam int SER_BITS = 16;
  localparam int FIFO_DEPTH = 4;
  localparam logic [5:0] CONV_LOAD = 6'(CONV_CYC - 2);
  localparam logic [5:0] CONV_MAX = 6'(CONV_CYC);
  localparam logic [5:0] SCLK_DELAY_LOAD = 6'(SCLK_DELAY_CYC - 1);
  localparam logic [5:0] HALF_LAST = 6'(2 * SER_BITS - 1);
  localparam logic [5:0] PULSES = 6'(SER_BITS);
  localparam logic [1:0] HALF_LOAD = 2'(SCLK_HALF_CYC - 1);
  // pin positions inside the synchroniser vector
  localparam int PIN_CS = 0;
  localparam int PIN_RC = 1;
  localparam int PIN_EXT = 2;
  localparam int PIN_FMT = 3;
  localparam int PIN_TAG = 4;
  localparam int PIN_N = 5;
  localparam logic [4:0] PIN_RST = 5'h03;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_STORE = 3'h4
  } ssr_conv_e;
endpackage

/* File: ssr_readout.sv */
// conversion control and serial result readout of a 16-bit sampling converter
// assumes a host drives the selects and, in external mode, the serial clock
`timescale 1ns/1ps
module ssr_readout (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic rconv_n,
  input wire logic ext_clk_mode,
  input wire logic format_select,
  input wire logic tag_in,
  input wire logic [15:0] sar_code,
  input wire logic serial_shift_clock_i,
  output logic serial_shift_clock_o,
  output logic serial_shift_clock_oe_n,
  output logic data_out,
  output logic sync_out,
  output logic busy_n
);
  ssr_fifo_if #(.W(ssr_pkg::WORD_W)) f_in ();
  ssr_fifo_if #(.W(ssr_pkg::WORD_W)) f_out ();

  ssr_fifo #(.W(ssr_pkg::WORD_W), .DEPTH(ssr_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .wr(f_in.dst),
    .rd(f_out.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, level moves once stages two and three agree
  logic [4:0] pins, s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;
  assign pins = {tag_in, format_select, ext_clk_mode, rconv_n, cs_n};

  always_comb begin
    nxt_lvl = (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= ssr_pkg::PIN_RST;
      s2_ff <= ssr_pkg::PIN_RST;
      s3_ff <= ssr_pkg::PIN_RST;
      lvl_ff <= ssr_pkg::PIN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  logic ext_lvl, fmt_lvl, tag_lvl, ctl, start;
  assign ext_lvl = lvl_ff[ssr_pkg::PIN_EXT];
  assign fmt_lvl = lvl_ff[ssr_pkg::PIN_FMT];
  assign tag_lvl = lvl_ff[ssr_pkg::PIN_TAG];
  // [RL10] selects ORed together
  assign ctl = lvl_ff[ssr_pkg::PIN_CS] | lvl_ff[ssr_pkg::PIN_RC];

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer, busy and result store
  ssr_pkg::ssr_conv_e st_ff, nxt_st;
  // transmitter state is read by the buffer handshake below, so it is declared here
  logic itx_act_ff, itx_run_ff, sclk_o_ff, int_data_ff, oe_n_ff, itx_tag_ff;
  logic nxt_itx_act, nxt_itx_run, nxt_sclk_o, nxt_int_data, nxt_itx_tag;
  // toggles on every entry into the read state; a level alone cannot be seen
  // by a link clock that stood still since the last read
  logic rd_seq_ff, nxt_rd_seq;
  logic [5:0] cnt_ff, nxt_cnt;
  logic ctl_prev_ff, busy_n_ff, nxt_busy_n, rd_state_ff, nxt_rd_state;
  logic [15:0] word_ff, nxt_word;

  // conversion starts on the second of the two falling selects
  assign start = ctl_prev_ff && !ctl && (st_ff == ssr_pkg::ST_IDLE);
  assign f_in.valid = (st_ff == ssr_pkg::ST_STORE);
  assign f_in.data = sar_code;
  // the word must not move while either read path is using it
  assign f_out.ready = !rd_state_ff && !nxt_rd_state && !itx_act_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_busy_n = busy_n_ff;
    nxt_word = word_ff;
    nxt_rd_state = ext_lvl && !lvl_ff[ssr_pkg::PIN_CS] && lvl_ff[ssr_pkg::PIN_RC];
    nxt_rd_seq = rd_seq_ff ^ (nxt_rd_state && !rd_state_ff);
    case (st_ff)
      ssr_pkg::ST_IDLE: begin
        if (start) begin
          // [RL11] busy falls at start
          nxt_busy_n = 1'b0;
          nxt_cnt = ssr_pkg::CONV_LOAD;
          nxt_st = ssr_pkg::ST_CONV;
        end
      end
      ssr_pkg::ST_CONV: begin
        // [RL4] bounded conversion time
        if (cnt_ff == '0) begin
          nxt_st = ssr_pkg::ST_STORE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ssr_pkg::ST_STORE: begin
        // [RL11] busy rises once stored
        if (f_in.ready) begin
          nxt_busy_n = 1'b1;
          nxt_st = ssr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = ssr_pkg::ST_IDLE;
      end
    endcase
    // [RL1] msb flip for two's complement
    if (f_out.valid && f_out.ready) begin
      nxt_word = {f_out.data[ssr_pkg::WORD_MSB] ^ !fmt_lvl, f_out.data[14:0]};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ssr_pkg::ST_IDLE;
      cnt_ff <= '0;
      ctl_prev_ff <= 1'b1;
      busy_n_ff <= 1'b1;
      rd_state_ff <= 1'b0;
      rd_seq_ff <= 1'b0;
      word_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ctl_prev_ff <= ctl;
      busy_n_ff <= nxt_busy_n;
      rd_state_ff <= nxt_rd_state;
      rd_seq_ff <= nxt_rd_seq;
      word_ff <= nxt_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal-clock transmitter: delay, then 16 pulses of the previous word
  logic [5:0] itx_dly_ff, nxt_itx_dly, half_ff, nxt_half;
  logic [1:0] tmr_ff, nxt_tmr;
  logic [15:0] itx_sh_ff, nxt_itx_sh;

  always_comb begin
    nxt_itx_act = itx_act_ff;
    nxt_itx_run = itx_run_ff;
    nxt_int_data = int_data_ff;
    nxt_itx_tag = itx_tag_ff;
    nxt_itx_dly = itx_dly_ff;
    nxt_half = half_ff;
    nxt_tmr = tmr_ff;
    nxt_itx_sh = itx_sh_ff;
    if (start && !ext_lvl) begin
      // [RL5] hold-off before first pulse
      nxt_itx_act = 1'b1;
      nxt_itx_run = 1'b0;
      nxt_itx_dly = ssr_pkg::SCLK_DELAY_LOAD;
      nxt_itx_sh = word_ff;
      nxt_itx_tag = tag_lvl;
    end else if (itx_act_ff && !itx_run_ff) begin
      if (itx_dly_ff == '0) begin
        nxt_itx_run = 1'b1;
        nxt_half = '0;
        nxt_tmr = ssr_pkg::HALF_LOAD;
        nxt_int_data = itx_sh_ff[ssr_pkg::WORD_MSB];
        nxt_itx_sh = {itx_sh_ff[14:0], itx_tag_ff};
      end else begin
        nxt_itx_dly = itx_dly_ff - 1'b1;
      end
    end else if (itx_run_ff) begin
      // [RL6] half period timer
      if (tmr_ff == '0) begin
        nxt_tmr = ssr_pkg::HALF_LOAD;
        // [RL12] stop after the last pulse
        if (half_ff == ssr_pkg::HALF_LAST) begin
          nxt_itx_act = 1'b0;
          nxt_itx_run = 1'b0;
          nxt_int_data = itx_sh_ff[ssr_pkg::WORD_MSB];
        end else begin
          nxt_half = half_ff + 1'b1;
          if (!nxt_half[0]) begin
            nxt_int_data = itx_sh_ff[ssr_pkg::WORD_MSB];
            nxt_itx_sh = {itx_sh_ff[14:0], itx_tag_ff};
          end
        end
      end else begin
        nxt_tmr = tmr_ff - 1'b1;
      end
    end
    // [RL12] clock low whenever idle
    nxt_sclk_o = nxt_itx_run && nxt_half[0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      itx_act_ff <= 1'b0;
      itx_run_ff <= 1'b0;
      sclk_o_ff <= 1'b0;
      int_data_ff <= 1'b0;
      itx_tag_ff <= 1'b0;
      itx_dly_ff <= '0;
      half_ff <= '0;
      tmr_ff <= '0;
      itx_sh_ff <= '0;
      oe_n_ff <= 1'b1;
    end else begin
      itx_act_ff <= nxt_itx_act;
      itx_run_ff <= nxt_itx_run;
      sclk_o_ff <= nxt_sclk_o;
      int_data_ff <= nxt_int_data;
      itx_tag_ff <= nxt_itx_tag;
      itx_dly_ff <= nxt_itx_dly;
      half_ff <= nxt_half;
      tmr_ff <= nxt_tmr;
      itx_sh_ff <= nxt_itx_sh;
      oe_n_ff <= ext_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external-clock domain; the word is quasi-static while the read state holds
  logic xr1_ff, xr2_ff, x_idle_ff, x_started_ff, x_sync_ff, x_data_ff;
  logic nxt_x_idle, nxt_x_started, nxt_x_sync, nxt_x_data;
  logic xt1_ff, xt2_ff, x_seen_ff, nxt_x_seen;
  logic [15:0] x_sh_ff, nxt_x_sh;

  always_comb begin
    nxt_x_idle = x_idle_ff;
    nxt_x_started = x_started_ff;
    nxt_x_sync = 1'b0;
    nxt_x_data = x_data_ff;
    nxt_x_sh = x_sh_ff;
    nxt_x_seen = x_seen_ff;
    if (!xr2_ff) begin
      // [RL2] remember an edge outside the read state
      nxt_x_idle = 1'b1;
      nxt_x_started = 1'b0;
    end else if (!x_started_ff || (xt2_ff != x_seen_ff)) begin
      // fresh read state: restart even if no edge came outside it
      nxt_x_started = 1'b1;
      nxt_x_seen = xt2_ff;
      nxt_x_idle = 1'b0;
      // [RL2] sync pulse precedes the msb
      if (x_idle_ff) begin
        nxt_x_sync = 1'b1;
        nxt_x_sh = word_ff;
      end else begin
        nxt_x_data = word_ff[ssr_pkg::WORD_MSB];
        nxt_x_sh = {word_ff[14:0], tag_in};
      end
    end else begin
      // [RL3] chain input shifts in behind the word
      // [RL13] chain level follows the 16 bits
      nxt_x_data = x_sh_ff[ssr_pkg::WORD_MSB];
      nxt_x_sh = {x_sh_ff[14:0], tag_in};
    end
  end

  always_ff @(posedge serial_shift_clock_i or negedge nrst) begin
    if (!nrst) begin
      xr1_ff <= 1'b0;
      xr2_ff <= 1'b0;
      xt1_ff <= 1'b0;
      xt2_ff <= 1'b0;
      x_seen_ff <= 1'b0;
      x_idle_ff <= 1'b0;
      x_started_ff <= 1'b0;
      x_sync_ff <= 1'b0;
      x_data_ff <= 1'b0;
      x_sh_ff <= '0;
    end else begin
      xr1_ff <= rd_state_ff;
      xr2_ff <= xr1_ff;
      xt1_ff <= rd_seq_ff;
      xt2_ff <= xt1_ff;
      x_seen_ff <= nxt_x_seen;
      x_idle_ff <= nxt_x_idle;
      x_started_ff <= nxt_x_started;
      x_sync_ff <= nxt_x_sync;
      x_data_ff <= nxt_x_data;
      x_sh_ff <= nxt_x_sh;
    end
  end

  // data pin picks the path of the selected clock mode
  assign data_out = ext_lvl ? x_data_ff : int_data_ff;
  assign sync_out = x_sync_ff;
  assign busy_n = busy_n_ff;
  assign serial_shift_clock_o = sclk_o_ff;
  assign serial_shift_clock_oe_n = oe_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // helper counters read only by the checks below
  logic [5:0] busy_cnt_ff, pulse_cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_ff <= '0;
      pulse_cnt_ff <= '0;
    end else begin
      busy_cnt_ff <= busy_n_ff ? 6'h00 : busy_cnt_ff + 6'h01;
      pulse_cnt_ff <= start ? 6'h00 : pulse_cnt_ff + 6'((nxt_sclk_o && !sclk_o_ff) ? 1 : 0);
    end
  end

  property p_busy_max;
    @(posedge clk) disable iff (!nrst)
    (!busy_n_ff && f_in.ready) |-> busy_cnt_ff < ssr_pkg::CONV_MAX;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy low too long"); // [RL4]
  property p_busy_fall;
    @(posedge clk) disable iff (!nrst)
    start |=> !busy_n_ff throughout (st_ff == ssr_pkg::ST_CONV)[*5];
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy not low in conversion"); // [RL11]
  property p_or_select;
    @(posedge clk) disable iff (!nrst)
    $fell(busy_n_ff) |-> $past(!ctl);
  endproperty
  a_or_select: assert property (p_or_select) else $error("start without both selects"); // [RL10]
  property p_sclk_delay;
    @(posedge clk) disable iff (!nrst)
    (start && !ext_lvl) |=> (!sclk_o_ff)[*5] ##1 !sclk_o_ff ##[1:2] sclk_o_ff;
  endproperty
  a_sclk_delay: assert property (p_sclk_delay) else $error("first clock pulse mistimed"); // [RL5]
  property p_sclk_period;
    @(posedge clk) disable iff (!nrst)
    $rose(sclk_o_ff) |=> !sclk_o_ff ##1 (sclk_o_ff || !itx_act_ff);
  endproperty
  a_sclk_period: assert property (p_sclk_period) else $error("clock period wrong"); // [RL6]
  property p_pulse_count;
    @(posedge clk) disable iff (!nrst)
    $fell(itx_act_ff) |-> (pulse_cnt_ff == ssr_pkg::PULSES) && !sclk_o_ff;
  endproperty
  a_pulse_count: assert property (p_pulse_count) else $error("pulse count not 16"); // [RL12]
  property p_fmt;
    @(posedge clk) disable iff (!nrst)
    (f_out.valid && f_out.ready) |=> word_ff[15] == ($past(f_out.data[15]) ^ !$past(fmt_lvl));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format bit wrong"); // [RL1]
  property p_sync_cause;
    @(posedge serial_shift_clock_i) disable iff (!nrst)
    x_sync_ff |-> $past(x_idle_ff) && $past(xr2_ff) && !x_idle_ff;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync without idle edge"); // [RL2]
endmodule

/* File: tb.sv */
// top testbench: drives selects and pins, judges the serial readout
// assumes the host model makes the link clock only in read bursts and in the stray pulse before a read
`timescale 1ns/1ps
module tb;
  logic clk;
  logic nrst;
  logic cs_n;
  logic rconv_n;
  logic ext_clk_mode;
  logic format_select;
  logic tag_in;
  logic [15:0] sar_code;
  logic host_sclk;
  logic sclk_wire;
  logic clk_o;
  logic oe_n;
  logic data_out;
  logic sync_out;
  logic busy_n;
  logic [15:0] prev_res;
  logic prev_ok;
  int n_fail;
  int cmp_count;

  ////////////////////////////////////////////////////////////////////////
  // shared clock pin: the device owns it while its enable is low
  assign sclk_wire = (oe_n === 1'b0) ? clk_o : host_sclk;

  ssr_readout ssr_readout_inst (
    .clk(clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .rconv_n(rconv_n),
    .ext_clk_mode(ext_clk_mode),
    .format_select(format_select),
    .tag_in(tag_in),
    .sar_code(sar_code),
    .serial_shift_clock_i(sclk_wire),
    .serial_shift_clock_o(clk_o),
    .serial_shift_clock_oe_n(oe_n),
    .data_out(data_out),
    .sync_out(sync_out),
    .busy_n(busy_n)
  );

  ssr_host_model ssr_host_model_inst (
    .sclk(host_sclk),
    .data_in(data_out),
    .sync_in(sync_out)
  );

  // 20 MHz system clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one conversion; in internal mode also judges the burst of the older word
  task automatic conv(input logic [15:0] code, input logic fmt, input logic tag);
    int nb;
    int nl;
    int first;
    int last;
    int np;
    logic prev;
    logic [15:0] w;
    nb = 0;
    nl = 0;
    first = 0;
    last = 0;
    np = 0;
    prev = 1'b0;
    w = 16'h0000;
    sar_code = code;
    format_select = fmt;
    tag_in = tag;
    cs_n = 1'b0;
    rconv_n = 1'b0;
    fork
      begin
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        rconv_n = 1'b1;
      end
      begin
        while (busy_n !== 1'b0 && nb < 10) begin
          @(negedge clk);
          nb++;
        end
        check(32'(nb >= 4 && nb <= 5), 32'h1);
        while (busy_n === 1'b0 && nl < 100) begin
          @(negedge clk);
          nl++;
        end
        check(32'(nl), 32'(2200 / 50));
      end
      begin
        // rising edges of the internal clock, counted in system cycles
        for (int k = 1; k <= 60 && !ext_clk_mode; k++) begin
          @(negedge clk);
          if (clk_o === 1'b1 && prev !== 1'b1) begin
            if (np == 0) first = k;
            else check(32'(k - last), 32'h2);
            last = k;
            w = {w[14:0], data_out};
            np++;
          end
          prev = clk_o;
        end
      end
    join
    // old word judged after the window
    if (!ext_clk_mode) begin
      check(32'(np), 32'h10);
      check(32'(clk_o), 32'h0);
      check(32'(oe_n), 32'h0);
      check(32'(first >= 10 && first <= 11), 32'h1);
      check(32'(data_out), 32'(tag));
      if (prev_ok) check(32'(w), 32'(prev_res));
    end
    prev_res = fmt ? code : {~code[15], code[14:0]};
    prev_ok = 1'b1;
    repeat (40) @(negedge clk);
  endtask

  // one read in external mode, optionally after a stray pulse outside it
  task automatic read_ext(input logic pre, input logic tag);
    int off;
    logic [15:0] w;
    off = pre ? 3 : 2;
    w = 16'h0000;
    tag_in = tag;
    if (pre) ssr_host_model_inst.burst(1);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (8) @(negedge clk);
    ssr_host_model_inst.burst(20);
    for (int i = 0; i < 16; i++) w = {w[14:0], ssr_host_model_inst.cap_d[off + i]};
    check(32'(w), 32'(prev_res));
    check(32'(ssr_host_model_inst.cap_s[2]), 32'(pre));
    check(32'(ssr_host_model_inst.cap_d[off + 16]), 32'(tag));
    @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cs_n = 1'b1;
    rconv_n = 1'b1;
    ext_clk_mode = 1'b0;
    format_select = 1'b1;
    tag_in = 1'b0;
    sar_code = 16'h0000;
    prev_res = 16'h0000;
    prev_ok = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check(32'(busy_n), 32'h1);
    rconv_n = 1'b0;
    repeat (10) @(negedge clk);
    check(32'(busy_n), 32'h1);
    rconv_n = 1'b1;
    repeat (6) @(negedge clk);
    conv(16'h8123, 1'b1, 1'b1);
    conv(16'h4ABC, 1'b0, 1'b0);
    conv(16'h0F0F, 1'b1, 1'b1);
    ext_clk_mode = 1'b1;
    repeat (6) @(negedge clk);
    read_ext(1'b1, 1'b1);
    conv(16'h7E01, 1'b0, 1'b0);
    read_ext(1'b0, 1'b0);
    test_done();
  end

  // watchdog: the run needs about 25 us, so 200 us means a hang
  initial begin
    #200000;
    check(32'h0, 32'h1);
    test_done();
  end
endmodule
